// ---- hw/ebcct_cfg.svh ----
// register offsets, field positions, reset values and timing counts of the timer
// assumes a 32-bit classic wishbone slave, one register per aligned word
`ifndef EBCCT_CFG_SVH
`define EBCCT_CFG_SVH

// register byte offsets
`define EBCCT_OFF_CTL2   8'h00
`define EBCCT_OFF_CTL1   8'h04
`define EBCCT_OFF_FLAGS  8'h08
`define EBCCT_OFF_CAPA   8'h0C
`define EBCCT_OFF_CMPA   8'h10
`define EBCCT_OFF_CNT    8'h14
`define EBCCT_OFF_MIRROR 8'h18
`define EBCCT_OFF_CAPB   8'h1C
`define EBCCT_OFF_CMPB   8'h20

// control one fields
`define EBCCT_C1_CAP_IE  7
`define EBCCT_C1_CMP_IE  6
`define EBCCT_C1_OVF_IE  5
`define EBCCT_C1_FORCE_B 4
`define EBCCT_C1_FORCE_A 3
`define EBCCT_C1_LEVEL_B 2
`define EBCCT_C1_EDGE_A  1
`define EBCCT_C1_LEVEL_A 0

// control two fields
`define EBCCT_C2_PIN_A_EN 7
`define EBCCT_C2_PIN_B_EN 6
`define EBCCT_C2_ONE_PULS 5
`define EBCCT_C2_PWM      4
`define EBCCT_C2_CLK_HI   3
`define EBCCT_C2_CLK_LO   2
`define EBCCT_C2_EDGE_B   1

// flag register fields
`define EBCCT_F_CAP_A   7
`define EBCCT_F_CMP_A   6
`define EBCCT_F_OVF     5
`define EBCCT_F_CAP_B   4
`define EBCCT_F_CMP_B   3
`define EBCCT_F_DISABLE 2

// reset values and the control two write mask
`define EBCCT_RST_CTL   8'h00
`define EBCCT_RST_COUNT 8'hFC
`define EBCCT_CTL2_MASK 8'hFE

// prescaler divisors in core clocks
`define EBCCT_DIV_2    14'd2
`define EBCCT_DIV_4    14'd4
`define EBCCT_DIV_8    14'd8
`define EBCCT_DIV_SLOW 14'd8000

`endif

// ---- hw/ebcct_pkg.sv ----
// types shared by the capture/compare timer
// assumes the constants header is included where offsets are needed
package ebcct_pkg;

  // wishbone request as seen by the slave
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ebcct_wb_req_t;

  // whether the flag-clear sequence is armed
  typedef enum logic [2:0] {
    EBCCT_ARM_NONE,
    EBCCT_ARM_ARMED
  } ebcct_arm_t;

  // one-pulse output phase
  typedef enum logic [1:0] {
    EBCCT_OP_IDLE,
    EBCCT_OP_PULSE
  } ebcct_op_t;

endpackage

// ---- hw/ebcct_timer.sv ----
// eight-bit capture/compare timer with wishbone register access
// assumes capture pins are asynchronous; one core clock, synchronous reset
// Contract
// - capture flags raise the interrupt when capture interrupt enable is set
// - compare flags raise the interrupt when compare interrupt enable is set
// - overflow flag raises the interrupt when overflow interrupt enable is set
// - force bits copy level bits to enabled compare pins immediately
// - compare B match drives level_b onto pin B when enabled
// - in pwm mode compare B drives level_b onto pin A instead; in one-pulse a capture A edge puts level_b on pin A
// - compare A match drives level_a onto pin A when enabled
// - edge select bits choose capture edge, zero falling, one rising
// - pin enables only gate the pins; compare logic keeps running
// - one-pulse mode: capture A edge starts one pulse, length from compare A
// - pwm mode: compare A sets pulse length, compare B sets period
// - clock select gives core over 4, 2, 8 or 8000
// - capture flag A sets on capture A edge, or compare B in pwm
// - flags clear by flag register read then own data register access
// - outside pwm, compare flags set when counter equals compare values; compare A flag not in one-pulse
// - overflow flag sets when counter wraps from all ones to zero
// - mirror counter reads count, write resets, never clears overflow
// - timer disable freezes prescaler and counter and disables outputs
// - any counter write reloads FC hex, data ignored
// - capture events copy counter into capture registers; capture A only outside one-pulse and pwm
// - pwm compare B event reloads counter with FC hex
// - pwm wins when both one-pulse and pwm are set
// - pwm compare values take effect only at period end
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "ebcct_cfg.svh"

module ebcct_timer
  import ebcct_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CLK_EN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             WB_ERR_O,
  input  wire logic        CAPTURE_PIN_A,
  input  wire logic        CAPTURE_PIN_B,
  output logic             COMPARE_OUTPUT_A,
  output logic             COMPARE_OUTPUT_A_OE_N,
  output logic             COMPARE_OUTPUT_B,
  output logic             COMPARE_OUTPUT_B_OE_N,
  output logic             TIMER_IRQ
);

  // bus request bundle
  ebcct_wb_req_t req;
  assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I,
                 sel: WB_SEL_I, dat: WB_DAT_I};

  // register state
  logic [7:0]  ctl1_q,   ctl1_d;
  logic [7:0]  ctl2_q,   ctl2_d;
  logic [4:0]  flag_q,   flag_d;      // cap_a cmp_a ovf cap_b cmp_b
  logic        dis_q,    dis_d;
  logic [4:0]  armed_q,  armed_d;     // flags seen set by a flag register read
  logic [7:0]  cnt_q,    cnt_d;
  logic [13:0] pre_q,    pre_d;
  logic [7:0]  capa_q,   capa_d;
  logic [7:0]  capb_q,   capb_d;
  logic [7:0]  cmpa_q,   cmpa_d;      // software view of compare values
  logic [7:0]  cmpb_q,   cmpb_d;
  logic [7:0]  acta_q,   acta_d;      // values the comparators actually use
  logic [7:0]  actb_q,   actb_d;
  logic        pina_q,   pina_d;
  logic        pinb_q,   pinb_d;
  ebcct_op_t   op_q,     op_d;
  logic        ack_q,    ack_d;
  logic        err_q,    err_d;
  logic [31:0] rdat_q,   rdat_d;
  logic [2:0]  sya_q,    syb_q;       // three-stage pin synchronisers

  // decoded modes
  logic pwm_mode, one_pulse;
  assign pwm_mode  = ctl2_q[`EBCCT_C2_PWM];
  assign one_pulse = ctl2_q[`EBCCT_C2_ONE_PULS] & ~pwm_mode;

  // prescaler divisor from the clock select field
  function automatic logic [13:0] divisor(input logic [1:0] sel);
    case (sel)
      2'b00:   divisor = `EBCCT_DIV_4;
      2'b01:   divisor = `EBCCT_DIV_2;
      2'b10:   divisor = `EBCCT_DIV_8;
      default: divisor = `EBCCT_DIV_SLOW;
    endcase
  endfunction

  // edge detect where second and third stages differ
  function automatic logic edge_seen(input logic [2:0] s, input logic rising);
    edge_seen = rising ? (s[1] & ~s[2]) : (~s[1] & s[2]);
  endfunction

  // capture pins pass three flops; stage 0 feeds only stage 1
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sya_q <= 3'h0;
      syb_q <= 3'h0;
    end else if (CLK_EN) begin
      sya_q <= {sya_q[1:0], CAPTURE_PIN_A};
      syb_q <= {syb_q[1:0], CAPTURE_PIN_B};
    end
  end

  // bus strobes
  logic acc, wr, rd;
  logic [7:0] wbyte;
  assign acc   = req.cyc & req.stb & ~ack_q & ~err_q;
  assign wr    = acc & req.we & req.sel[0];
  assign rd    = acc & ~req.we;
  assign wbyte = req.dat[7:0];

  // events
  logic tick, edge_a, edge_b, match_a, match_b, wrap, cnt_wr;
  assign tick    = ~dis_q & (pre_q == divisor(ctl2_q[3:2]) - 14'd1);
  assign edge_a  = edge_seen(sya_q, ctl1_q[`EBCCT_C1_EDGE_A]);
  assign edge_b  = edge_seen(syb_q, ctl2_q[`EBCCT_C2_EDGE_B]);
  assign match_a = tick & (cnt_q == acta_q);
  assign match_b = tick & (cnt_q == actb_q);
  assign wrap    = tick & (cnt_q == 8'hFF) & ~(pwm_mode & match_b);
  assign cnt_wr  = acc & req.we &
                   (req.adr == `EBCCT_OFF_CNT || req.adr == `EBCCT_OFF_MIRROR);

  // next-state for the whole timer and its register file
  always_comb begin
    logic [4:0] clr;
    logic [4:0] set;
    clr      = 5'h00;
    set      = 5'h00;
    ctl1_d   = ctl1_q;
    ctl2_d   = ctl2_q;
    dis_d    = dis_q;
    armed_d  = armed_q;
    cmpa_d   = cmpa_q;
    cmpb_d   = cmpb_q;
    acta_d   = acta_q;
    actb_d   = actb_q;
    capa_d   = capa_q;
    capb_d   = capb_q;
    pina_d   = pina_q;
    pinb_d   = pinb_q;
    op_d     = op_q;
    ack_d    = 1'b0;
    err_d    = 1'b0;
    rdat_d   = rdat_q;
    pre_d    = dis_q ? pre_q : (tick ? 14'd0 : pre_q + 14'd1);
    cnt_d    = tick ? cnt_q + 8'd1 : cnt_q;

    // bus: one-cycle ack for mapped words, err otherwise
    if (acc) begin
      rdat_d = 32'h0000_0000;
      if (req.adr == `EBCCT_OFF_CTL2) begin
        rdat_d[7:0] = ctl2_q;
        if (wr) ctl2_d = wbyte & `EBCCT_CTL2_MASK;
        ack_d = 1'b1;
      end else if (req.adr == `EBCCT_OFF_CTL1) begin
        rdat_d[7:0] = ctl1_q;
        if (wr) ctl1_d = wbyte;
        ack_d = 1'b1;
      end else if (req.adr == `EBCCT_OFF_FLAGS) begin
        rdat_d[7:0] = {flag_q, dis_q, 2'b00};
        if (wr) dis_d = wbyte[`EBCCT_F_DISABLE];
        if (rd) armed_d = flag_q;
        ack_d = 1'b1;
      end else if (req.adr == `EBCCT_OFF_CAPA) begin
        rdat_d[7:0] = capa_q;
        clr[4] = armed_q[4];
        ack_d = 1'b1;
      end else if (req.adr == `EBCCT_OFF_CMPA) begin
        rdat_d[7:0] = cmpa_q;
        if (wr) cmpa_d = wbyte;
        clr[3] = armed_q[3];
        ack_d = 1'b1;
      end else if (req.adr == `EBCCT_OFF_CNT) begin
        rdat_d[7:0] = cnt_q;
        clr[2] = armed_q[2];
        ack_d = 1'b1;
      end else if (req.adr == `EBCCT_OFF_MIRROR) begin
        rdat_d[7:0] = cnt_q;
        ack_d = 1'b1;
      end else if (req.adr == `EBCCT_OFF_CAPB) begin
        rdat_d[7:0] = capb_q;
        clr[1] = armed_q[1];
        ack_d = 1'b1;
      end else if (req.adr == `EBCCT_OFF_CMPB) begin
        rdat_d[7:0] = cmpb_q;
        if (wr) cmpb_d = wbyte;
        clr[0] = armed_q[0];
        ack_d = 1'b1;
      end else begin
        err_d = 1'b1;
      end
      armed_d = armed_d & ~clr;
    end

    // outside pwm the comparators follow the written values at once
    if (!pwm_mode) begin
      acta_d = cmpa_d;
      actb_d = cmpb_d;
    end

    // event flags; set beats a same-cycle clear
    set[4] = (edge_a & ~pwm_mode) | (pwm_mode & match_b);
    set[3] = match_a & ~pwm_mode & ~one_pulse;
    set[2] = wrap;
    set[1] = edge_b;
    set[0] = match_b & ~pwm_mode;
    flag_d = (flag_q & ~clr) | set;

    // capture registers latch the count on their own events
    if (edge_a && !pwm_mode && !one_pulse) capa_d = cnt_q;
    if (edge_b) capb_d = cnt_q;

    // compare outputs by mode
    if (pwm_mode) begin
      if (match_b) begin
        pina_d = ctl1_q[`EBCCT_C1_LEVEL_B];
        cnt_d  = `EBCCT_RST_COUNT;
        acta_d = cmpa_q;
        actb_d = cmpb_q;
      end else if (match_a) begin
        pina_d = ctl1_q[`EBCCT_C1_LEVEL_A];
      end
    end else if (one_pulse) begin
      case (op_q)
        EBCCT_OP_IDLE: begin
          if (edge_a) begin
            pina_d = ctl1_q[`EBCCT_C1_LEVEL_B];
            cnt_d  = `EBCCT_RST_COUNT;
            op_d   = EBCCT_OP_PULSE;
          end
        end
        default: begin
          if (match_a) begin
            pina_d = ctl1_q[`EBCCT_C1_LEVEL_A];
            op_d   = EBCCT_OP_IDLE;
          end
        end
      endcase
      if (match_b) pinb_d = ctl1_q[`EBCCT_C1_LEVEL_B];
    end else begin
      op_d = EBCCT_OP_IDLE;
      if (match_a) pina_d = ctl1_q[`EBCCT_C1_LEVEL_A];
      if (match_b) pinb_d = ctl1_q[`EBCCT_C1_LEVEL_B];
    end

    // force bits act whatever the compare state
    if (ctl1_q[`EBCCT_C1_FORCE_A]) pina_d = ctl1_q[`EBCCT_C1_LEVEL_A];
    if (ctl1_q[`EBCCT_C1_FORCE_B]) pinb_d = ctl1_q[`EBCCT_C1_LEVEL_B];

    // counter write reloads, data ignored; wins over counting
    if (cnt_wr) begin
      cnt_d = `EBCCT_RST_COUNT;
      pre_d = 14'd0;
    end
  end

  // registers only
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ctl1_q <= `EBCCT_RST_CTL;
      ctl2_q <= `EBCCT_RST_CTL;
      flag_q <= 5'h00;
      dis_q  <= 1'b0;
      armed_q <= 5'h00;
      cnt_q  <= `EBCCT_RST_COUNT;
      pre_q  <= 14'd0;
      capa_q <= 8'h00;
      capb_q <= 8'h00;
      cmpa_q <= `EBCCT_RST_CTL;
      cmpb_q <= `EBCCT_RST_CTL;
      acta_q <= `EBCCT_RST_CTL;
      actb_q <= `EBCCT_RST_CTL;
      pina_q <= 1'b0;
      pinb_q <= 1'b0;
      op_q   <= EBCCT_OP_IDLE;
      ack_q  <= 1'b0;
      err_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else if (CLK_EN) begin
      ctl1_q <= ctl1_d;
      ctl2_q <= ctl2_d;
      flag_q <= flag_d;
      dis_q  <= dis_d;
      armed_q <= armed_d;
      cnt_q  <= cnt_d;
      pre_q  <= pre_d;
      capa_q <= capa_d;
      capb_q <= capb_d;
      cmpa_q <= cmpa_d;
      cmpb_q <= cmpb_d;
      acta_q <= acta_d;
      actb_q <= actb_d;
      pina_q <= pina_d;
      pinb_q <= pinb_d;
      op_q   <= op_d;
      ack_q  <= ack_d;
      err_q  <= err_d;
      rdat_q <= rdat_d;
    end
  end

  // pins: enable only gates the pin, disable bit kills the drive
  assign COMPARE_OUTPUT_A      = pina_q;
  assign COMPARE_OUTPUT_B      = pinb_q;
  assign COMPARE_OUTPUT_A_OE_N = ~(ctl2_q[`EBCCT_C2_PIN_A_EN] & ~dis_q);
  assign COMPARE_OUTPUT_B_OE_N = ~(ctl2_q[`EBCCT_C2_PIN_B_EN] & ~dis_q);

  // single request line for all enabled flags
  assign TIMER_IRQ = (ctl1_q[`EBCCT_C1_CAP_IE] & (flag_q[4] | flag_q[1])) |
                     (ctl1_q[`EBCCT_C1_CMP_IE] & (flag_q[3] | flag_q[0])) |
                     (ctl1_q[`EBCCT_C1_OVF_IE] & flag_q[2]);

  assign WB_DAT_O = rdat_q;
  assign WB_ACK_O = ack_q;
  assign WB_ERR_O = err_q;

endmodule

// ---- testbench/ebcct_timer_monitor.sv ----
// port-level checker for the capture/compare timer
// assumes bind to ebcct_timer, CLK_EN high whenever a write is taken
`timescale 1ns/1ps
`include "ebcct_cfg.svh"
module ebcct_timer_monitor (
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic        CLK_EN,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        WB_ERR_O,
  input wire logic        COMPARE_OUTPUT_A,
  input wire logic        COMPARE_OUTPUT_A_OE_N,
  input wire logic        COMPARE_OUTPUT_B,
  input wire logic        COMPARE_OUTPUT_B_OE_N,
  input wire logic        TIMER_IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  logic [7:0] c1_q, c1_d, c2_q, c2_d;
  logic       dis_q, dis_d, take;
  assign take = CLK_EN && WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  // shadow of the control bits; the registers are hidden, so rebuild them from the bus
  always_comb begin
    c1_d  = c1_q;
    c2_d  = c2_q;
    dis_d = dis_q;
    if (take && WB_WE_I && WB_SEL_I[0]) begin
      if (WB_ADR_I == `EBCCT_OFF_CTL1) c1_d = WB_DAT_I[7:0];
      if (WB_ADR_I == `EBCCT_OFF_CTL2) c2_d = WB_DAT_I[7:0];
      if (WB_ADR_I == `EBCCT_OFF_FLAGS) dis_d = WB_DAT_I[`EBCCT_F_DISABLE];
    end
  end
  // register the shadow
  always_ff @(posedge CORE_CLK) begin
    c1_q  <= SYS_RST ? 8'h00 : c1_d;
    c2_q  <= SYS_RST ? 8'h00 : c2_d;
    dis_q <= SYS_RST ? 1'b0 : dis_d;
  end
  AST_ACK_NEXT: assert property (take |=> (WB_ACK_O ^ WB_ERR_O))
    else $error("no single answer after a taken request");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  AST_ERR_UNMAP: assert property (take && WB_ADR_I > `EBCCT_OFF_CMPB |=> WB_ERR_O)
    else $error("unmapped address not refused");
  AST_DAT_HI: assert property ($rose(WB_ACK_O) |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_OE_A: assert property (COMPARE_OUTPUT_A_OE_N == !(c2_q[7] && !dis_q))
    else $error("pin A enable wrong");
  AST_OE_B: assert property (COMPARE_OUTPUT_B_OE_N == !(c2_q[6] && !dis_q))
    else $error("pin B enable wrong");
  AST_IRQ_MASK: assert property (c1_q[7:5] == 3'h0 |-> !TIMER_IRQ)
    else $error("interrupt with all enables clear");
  AST_FORCE_A: assert property (c1_q[3] && c2_q[7] && c2_q[5:4] == 2'h0 && !dis_q
    && $stable(c1_q) |=> COMPARE_OUTPUT_A == $past(c1_q[0]))
    else $error("forced level A not on pin");
  AST_FORCE_B: assert property (c1_q[4] && c2_q[6] && !dis_q && $stable(c1_q)
    ##1 1'b1 |-> COMPARE_OUTPUT_B == $past(c1_q[2]))
    else $error("forced level B not on pin");
endmodule
bind ebcct_timer ebcct_timer_monitor ebcct_timer_monitor_i (.*);

// ---- testbench/testbench.sv ----
// register-level bench for the capture/compare timer
// assumes one-cycle wishbone answer; CLK_EN and byte select held on
`timescale 1ns/1ps
`include "ebcct_cfg.svh"
module testbench;
  import ebcct_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        we  = 1'b0;
  logic        pa  = 1'b0;
  logic        pb  = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [7:0]  rd;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack, err, oa, oa_n, ob, ob_n, irq;
  int          errors = 0, num_checks = 0, now = 0, t_a, t0;
  int          div [4] = '{`EBCCT_DIV_4, `EBCCT_DIV_2, `EBCCT_DIV_8, `EBCCT_DIV_SLOW};
  ebcct_timer ebcct_timer_i (
    .CORE_CLK              (clk),
    .SYS_RST               (rst),
    .CLK_EN                (1'b1),
    .WB_CYC_I              (cyc),
    .WB_STB_I              (cyc),
    .WB_WE_I               (we),
    .WB_ADR_I              (adr),
    .WB_SEL_I              (4'hF),
    .WB_DAT_I              (wdat),
    .WB_DAT_O              (rdat),
    .WB_ACK_O              (ack),
    .WB_ERR_O              (err),
    .CAPTURE_PIN_A         (pa),
    .CAPTURE_PIN_B         (pb),
    .COMPARE_OUTPUT_A      (oa),
    .COMPARE_OUTPUT_A_OE_N (oa_n),
    .COMPARE_OUTPUT_B      (ob),
    .COMPARE_OUTPUT_B_OE_N (ob_n),
    .TIMER_IRQ             (irq)
  );
  // 125 MHz core clock and a cycle count used to time the counting window
  always #4 clk = ~clk;
  always @(posedge clk) now <= now + 1;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; tk is the cycle at which the slave takes it
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output int tk);
    @(posedge clk);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    tk = now + 1;
    do @(posedge clk); while (!(ack || err));
    rd = rdat[7:0];
    cyc <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, t_a);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, t_a);
    check(rd, exp);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // freeze first so later captures and counts are exact
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wr(`EBCCT_OFF_FLAGS, 8'h04);
    rc(`EBCCT_OFF_CNT, 8'hFC);
    rc(`EBCCT_OFF_MIRROR, 8'hFC);
    rc(`EBCCT_OFF_CTL1, 8'h00);
    rc(`EBCCT_OFF_CTL2, 8'h00);
    rc(`EBCCT_OFF_CMPA, 8'h00);
    rc(`EBCCT_OFF_CMPB, 8'h00);
    bus(1'b0, 8'h24, 8'h00, t_a);
    check({7'h0, err}, 8'h01);
    wr(`EBCCT_OFF_CTL1, 8'h02);
    pa <= 1'b1;
    pb <= 1'b0;
    repeat (8) @(posedge clk);
    rc(`EBCCT_OFF_FLAGS, 8'h94);
    rc(`EBCCT_OFF_CAPA, 8'hFC);
    rc(`EBCCT_OFF_FLAGS, 8'h14);
    rc(`EBCCT_OFF_CAPB, 8'hFC);
    rc(`EBCCT_OFF_FLAGS, 8'h04);
    // every clock select, counter reload through both count registers
    for (int cs = 0; cs < 4; cs++) begin
      wr(`EBCCT_OFF_CTL2, 8'(cs << 2));
      wr(cs[0] ? `EBCCT_OFF_MIRROR : `EBCCT_OFF_CNT, 8'h5A);
      wr(`EBCCT_OFF_FLAGS, 8'h00);
      t0 = t_a;
      repeat (5 * div[cs]) @(posedge clk);
      wr(`EBCCT_OFF_FLAGS, 8'h04);
      rc(`EBCCT_OFF_CNT, 8'(8'hFC + (t_a - t0) / div[cs]));
    end
    rc(`EBCCT_OFF_FLAGS, 8'h6C);
    for (int i = 5; i < 8; i++) begin
      wr(`EBCCT_OFF_CTL1, 8'(1 << i));
      check({7'h0, irq}, {7'h0, i != 7});
    end
    bus(1'b0, `EBCCT_OFF_MIRROR, 8'h00, t_a);
    rc(`EBCCT_OFF_FLAGS, 8'h6C);
    bus(1'b0, `EBCCT_OFF_CNT, 8'h00, t_a);
    rc(`EBCCT_OFF_FLAGS, 8'h4C);
    bus(1'b0, `EBCCT_OFF_CMPA, 8'h00, t_a);
    bus(1'b0, `EBCCT_OFF_CMPB, 8'h00, t_a);
    rc(`EBCCT_OFF_FLAGS, 8'h04);
    // forced levels reach enabled pins while the counter runs
    wr(`EBCCT_OFF_CTL2, 8'hC0);
    wr(`EBCCT_OFF_CTL1, 8'h1D);
    wr(`EBCCT_OFF_FLAGS, 8'h00);
    repeat (3) @(posedge clk);
    check({4'h0, oa_n, ob_n, oa, ob}, 8'h03);
    wr(`EBCCT_OFF_CTL1, 8'h18);
    repeat (3) @(posedge clk);
    check({4'h0, oa_n, ob_n, oa, ob}, 8'h00);
    wr(`EBCCT_OFF_FLAGS, 8'h04);
    check({6'h0, oa_n, ob_n}, 8'h03);
    // pwm: period ends at compare B, which sets capture flag A but no compare flag
    wr(`EBCCT_OFF_CTL1, 8'h04);
    wr(`EBCCT_OFF_CMPA, 8'hFE);
    wr(`EBCCT_OFF_CMPB, 8'h02);
    wr(`EBCCT_OFF_CNT, 8'h00);
    wr(`EBCCT_OFF_CTL2, 8'h90);
    wr(`EBCCT_OFF_FLAGS, 8'h00);
    repeat (40) @(posedge clk);
    wr(`EBCCT_OFF_FLAGS, 8'h04);
    rc(`EBCCT_OFF_FLAGS, 8'hA4);
    report_and_stop();
  end
  // the slowest select alone needs some 40000 cycles; the rest is a few hundred
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule
